// File: pkg/mdfc_pkg.sv
// Constants and types for the MAC DMA flow control block.
// Assumes a 32-bit AXI4-Lite register bus and byte-counted FIFO levels.
package mdfc_pkg;
	// --------------------------------------------------------------
	// Register byte addresses
	// --------------------------------------------------------------
	localparam logic [31:0] ADDR_TX_DEMAND = 32'hb00030a0;
	localparam logic [31:0] ADDR_RX_DEMAND = 32'hb00030a4;
	localparam logic [31:0] ADDR_MAX_LEN   = 32'hb00030a8;
	localparam logic [31:0] ADDR_CTRL      = 32'hb00030c0;
	localparam logic [31:0] ADDR_STATUS    = 32'hb00030c4;
	localparam logic [31:0] ADDR_IRQ_STAT  = 32'hb00030c8;
	localparam logic [31:0] ADDR_IRQ_MASK  = 32'hb00030cc;
	// --------------------------------------------------------------
	// Field positions and reset values
	// --------------------------------------------------------------
	localparam int          CTRL_TRANSMIT_ON_BIT   = 0;
	localparam int          CTRL_RECEIVE_ON_BIT   = 1;
	localparam int          CTRL_THD_LSB    = 2;
	localparam int          CTRL_BLEN_LSB   = 4;
	localparam int          CTRL_OVL_EN_BIT = 8;
	localparam logic [1:0]  THD_RESET       = 2'h1;
	localparam logic [1:0]  BLEN_RESET      = 2'h0;
	localparam logic [15:0] MAX_LEN_RESET   = 16'h0800;
	localparam int          IRQ_W           = 3;
	localparam int          IRQ_OVL_BIT     = 0;
	localparam int          IRQ_TXHALT_BIT  = 1;
	localparam int          IRQ_RXHALT_BIT  = 2;
	localparam int          STAT_TXHALT_BIT = 0;
	localparam int          STAT_RXHALT_BIT = 1;
	localparam int          STAT_REQ_BIT    = 2;
	// --------------------------------------------------------------
	// Threshold and burst figures
	// --------------------------------------------------------------
	localparam int          THD1_HIGH_B    = 64;
	localparam int          THD2_HIGH_B    = 128;
	localparam int          THD3_HIGH_B    = 192;
	localparam int          BURST0_WORDS   = 4;
	localparam int          BURST1_WORDS   = 8;
	localparam int          BURST2_WORDS   = 16;
	localparam int          BURST3_WORDS   = 16;
	localparam int          BYTES_PER_WORD = 4;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	// --------------------------------------------------------------
	// DMA engine states
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		st_idle,
		st_run,
		st_halt
	} mdfc_dma_st_t;
endpackage : mdfc_pkg

// File: rtl/mdfc_flow_ctrl.sv
// MAC DMA flow control: receive thresholds, DMA halt and resume,
// maximum receive frame length check, AXI4-Lite registers, interrupt.
// Assumes the FIFO level, descriptor flags and frame events are synchronous to aclk.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
module mdfc_flow_ctrl #(
	parameter int LVL_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              tx_desc_avail,
	input  wire logic              rx_desc_avail,
	input  wire logic              rx_frame_active,
	input  wire logic [LVL_W-1:0]  rx_fifo_level,
	input  wire logic              rx_frame_done,
	input  wire logic [15:0]       rx_frame_len,
	output logic                   rx_dma_req,
	output logic                   tx_dma_halted,
	output logic                   rx_dma_halted,
	output logic                   transmit_on,
	output logic                   receive_on,
	output logic [1:0]             burst_len,
	output logic                   irq
);
	// --------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------
	localparam int IRQ_W_L = mdfc_pkg::IRQ_W;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       rdata_reg;
	logic [31:0]       waddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              aw_got_reg;
	logic              w_got_reg;
	logic              wr_go;
	logic [31:0]       ctrl_reg;
	logic [15:0]       max_len_reg;
	logic [IRQ_W_L-1:0] irq_stat_reg;
	logic [IRQ_W_L-1:0] irq_mask_reg;
	logic [IRQ_W_L-1:0] irq_stat_next;
	logic              irq_reg;
	logic              tx_demand_reg;
	logic              rx_demand_reg;
	logic              rx_req_reg;
	logic              tx_halt_evt;
	logic              rx_halt_evt;
	logic [LVL_W-1:0]  high_b;
	logic [LVL_W-1:0]  low_b;
	logic              ovl_evt;
	logic [31:0]       rd_val;
	logic              rd_ok;

	if (LVL_W < 8 || LVL_W > 16) begin : g_chk
		$error("LVL_W must lie in 8..16");
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			old[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
		merge = old;
	endfunction : merge

	function automatic logic mapped(input logic [31:0] a);
		mapped = a == mdfc_pkg::ADDR_TX_DEMAND || a == mdfc_pkg::ADDR_RX_DEMAND ||
			a == mdfc_pkg::ADDR_MAX_LEN || a == mdfc_pkg::ADDR_CTRL ||
			a == mdfc_pkg::ADDR_STATUS || a == mdfc_pkg::ADDR_IRQ_STAT ||
			a == mdfc_pkg::ADDR_IRQ_MASK;
	endfunction : mapped

	// --------------------------------------------------------------
	// AXI4-Lite write channel
	// --------------------------------------------------------------
	assign wr_go = aw_got_reg && w_got_reg && !bvalid_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= mdfc_pkg::RESP_OKAY;
			waddr_reg   <= 32'h0;
			wdata_reg   <= 32'h0;
			wstrb_reg   <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_reg) begin
				awready_reg <= 1'b0;
				aw_got_reg  <= 1'b1;
				waddr_reg   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_reg) begin
				wready_reg <= 1'b0;
				w_got_reg  <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg  <= mapped(waddr_reg) ? mdfc_pkg::RESP_OKAY : mdfc_pkg::RESP_SLVERR;
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	// --------------------------------------------------------------
	// Software registers and demand pulses
	// --------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= 32'h0;
			ctrl_reg[mdfc_pkg::CTRL_THD_LSB +: 2]  <= mdfc_pkg::THD_RESET;
			ctrl_reg[mdfc_pkg::CTRL_BLEN_LSB +: 2] <= mdfc_pkg::BLEN_RESET;
			max_len_reg  <= mdfc_pkg::MAX_LEN_RESET;
			irq_mask_reg <= '0;
		end else if (wr_go) begin
			case (waddr_reg)
				mdfc_pkg::ADDR_CTRL:
					ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & 32'h0000013f;
				mdfc_pkg::ADDR_MAX_LEN:
					max_len_reg <= 16'(merge({16'h0, max_len_reg}, wdata_reg, wstrb_reg));
				mdfc_pkg::ADDR_IRQ_MASK:
					irq_mask_reg <= IRQ_W_L'(merge({29'h0, irq_mask_reg}, wdata_reg,
						wstrb_reg));
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_demand_reg <= 1'b0;
			rx_demand_reg <= 1'b0;
		end else begin
			tx_demand_reg <= wr_go && waddr_reg == mdfc_pkg::ADDR_TX_DEMAND;
			rx_demand_reg <= wr_go && waddr_reg == mdfc_pkg::ADDR_RX_DEMAND;
		end
	end

	assign transmit_on = ctrl_reg[mdfc_pkg::CTRL_TRANSMIT_ON_BIT];
	assign receive_on  = ctrl_reg[mdfc_pkg::CTRL_RECEIVE_ON_BIT];
	assign burst_len   = ctrl_reg[mdfc_pkg::CTRL_BLEN_LSB +: 2];

	// --------------------------------------------------------------
	// AXI4-Lite read channel
	// --------------------------------------------------------------
	always_comb begin
		rd_val = 32'h0;
		rd_ok  = 1'b1;
		case (s_axi_araddr)
			mdfc_pkg::ADDR_TX_DEMAND: rd_val = 32'h0;
			mdfc_pkg::ADDR_RX_DEMAND: rd_val = 32'h0;
			mdfc_pkg::ADDR_MAX_LEN:   rd_val = {16'h0, max_len_reg};
			mdfc_pkg::ADDR_CTRL:      rd_val = ctrl_reg;
			mdfc_pkg::ADDR_STATUS: begin
				rd_val[mdfc_pkg::STAT_TXHALT_BIT] = tx_dma_halted;
				rd_val[mdfc_pkg::STAT_RXHALT_BIT] = rx_dma_halted;
				rd_val[mdfc_pkg::STAT_REQ_BIT]    = rx_req_reg;
			end
			mdfc_pkg::ADDR_IRQ_STAT:  rd_val = {29'h0, irq_stat_reg};
			mdfc_pkg::ADDR_IRQ_MASK:  rd_val = {29'h0, irq_mask_reg};
			default:                  rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= mdfc_pkg::RESP_OKAY;
			rdata_reg   <= 32'h0;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_val;
			rresp_reg   <= rd_ok ? mdfc_pkg::RESP_OKAY : mdfc_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	// --------------------------------------------------------------
	// DMA halt engines and receive thresholds
	// --------------------------------------------------------------
	mdfc_halt_fsm u_tx_fsm (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.dma_on     (transmit_on),
		.desc_avail (tx_desc_avail),
		.demand     (tx_demand_reg),
		.halted     (tx_dma_halted),
		.halt_evt   (tx_halt_evt)
	);

	mdfc_halt_fsm u_rx_fsm (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.dma_on     (receive_on),
		.desc_avail (rx_desc_avail),
		.demand     (rx_demand_reg),
		.halted     (rx_dma_halted),
		.halt_evt   (rx_halt_evt)
	);

	mdfc_rx_thresh #(
		.LVL_W (LVL_W)
	) u_thresh (
		.thd_sel   (ctrl_reg[mdfc_pkg::CTRL_THD_LSB +: 2]),
		.burst_len (burst_len),
		.high_b    (high_b),
		.low_b     (low_b)
	);

	// Hysteresis: request held between the two thresholds
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rx_req_reg <= 1'b0;
		else if (!rx_frame_active || rx_dma_halted)
			rx_req_reg <= 1'b0;
		else if (rx_fifo_level < low_b)
			rx_req_reg <= 1'b0;
		else if (rx_fifo_level >= high_b)
			rx_req_reg <= 1'b1;
	end

	assign rx_dma_req = rx_req_reg;

	// --------------------------------------------------------------
	// Interrupt status, mask and output
	// --------------------------------------------------------------
	assign ovl_evt = rx_frame_done && rx_frame_len > max_len_reg &&
		ctrl_reg[mdfc_pkg::CTRL_OVL_EN_BIT];

	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (wr_go && waddr_reg == mdfc_pkg::ADDR_IRQ_STAT && wstrb_reg[0])
			irq_stat_next = irq_stat_reg & ~wdata_reg[IRQ_W_L-1:0];
		// Set wins over a clear in the same cycle
		irq_stat_next[mdfc_pkg::IRQ_OVL_BIT]    = irq_stat_next[mdfc_pkg::IRQ_OVL_BIT] | ovl_evt;
		irq_stat_next[mdfc_pkg::IRQ_TXHALT_BIT] = irq_stat_next[mdfc_pkg::IRQ_TXHALT_BIT] |
			tx_halt_evt;
		irq_stat_next[mdfc_pkg::IRQ_RXHALT_BIT] = irq_stat_next[mdfc_pkg::IRQ_RXHALT_BIT] |
			rx_halt_evt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_reg <= '0;
			irq_reg      <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_reg      <= |(irq_stat_next & irq_mask_reg);
		end
	end

	assign irq = irq_reg;

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	property p_low_half;
		@(posedge aclk) disable iff (!aresetn)
		low_b == (high_b >> 1);
	endproperty
	a_low_half: assert property (p_low_half)
		else $error("low threshold not half of high");

	property p_req_start;
		@(posedge aclk) disable iff (!aresetn)
		rx_frame_active && !rx_dma_halted && rx_fifo_level >= high_b |=> rx_dma_req;
	endproperty
	a_req_start: assert property (p_req_start)
		else $error("no request at high threshold");

	property p_req_stop;
		@(posedge aclk) disable iff (!aresetn)
		rx_fifo_level < low_b |=> !rx_dma_req;
	endproperty
	a_req_stop: assert property (p_req_stop)
		else $error("request kept below low threshold");

	property p_sel0;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[mdfc_pkg::CTRL_THD_LSB +: 2] == 2'h0 && burst_len == 2'h1
			|-> high_b == LVL_W'(32);
	endproperty
	a_sel0: assert property (p_sel0)
		else $error("eight-word burst threshold wrong");

	property p_sel3;
		@(posedge aclk) disable iff (!aresetn)
		ctrl_reg[mdfc_pkg::CTRL_THD_LSB +: 2] == 2'h3 |-> high_b == LVL_W'(192) &&
			low_b == LVL_W'(96);
	endproperty
	a_sel3: assert property (p_sel3)
		else $error("select three thresholds wrong");

	property p_demand_read;
		@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == mdfc_pkg::ADDR_RX_DEMAND
			|=> s_axi_rvalid && s_axi_rdata == 32'h0;
	endproperty
	a_demand_read: assert property (p_demand_read)
		else $error("demand register read not zero");

	property p_ovl_flag;
		@(posedge aclk) disable iff (!aresetn)
		ovl_evt && irq_mask_reg[mdfc_pkg::IRQ_OVL_BIT]
			|=> irq_stat_reg[mdfc_pkg::IRQ_OVL_BIT] && irq;
	endproperty
	a_ovl_flag: assert property (p_ovl_flag)
		else $error("over-length did not raise interrupt");

	property p_tx_resume;
		@(posedge aclk) disable iff (!aresetn)
		wr_go && waddr_reg == mdfc_pkg::ADDR_TX_DEMAND && tx_dma_halted && transmit_on
			##1 transmit_on |=> !tx_dma_halted;
	endproperty
	a_tx_resume: assert property (p_tx_resume)
		else $error("transmit demand did not resume");
endmodule : mdfc_flow_ctrl

// File: rtl/mdfc_halt_fsm.sv
// Halt and resume state machine shared by the transmit and receive DMA.
// Assumes demand is a one-cycle pulse per register write.
`timescale 1ns/100ps
module mdfc_halt_fsm (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic dma_on,
	input  wire logic desc_avail,
	input  wire logic demand,
	output logic      halted,
	output logic      halt_evt
);
	mdfc_pkg::mdfc_dma_st_t st_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg   <= mdfc_pkg::st_idle;
			halt_evt <= 1'b0;
			halted   <= 1'b0;
		end else begin
			halt_evt <= 1'b0;
			case (st_reg)
				mdfc_pkg::st_idle:
					if (dma_on)
						st_reg <= mdfc_pkg::st_run;
				mdfc_pkg::st_run:
					if (!dma_on)
						st_reg <= mdfc_pkg::st_idle;
					else if (!desc_avail) begin
						st_reg   <= mdfc_pkg::st_halt;
						halted   <= 1'b1;
						halt_evt <= 1'b1;
					end
				mdfc_pkg::st_halt:
					if (!dma_on) begin
						st_reg <= mdfc_pkg::st_idle;
						halted <= 1'b0;
					end else if (demand) begin
						st_reg <= mdfc_pkg::st_run;
						halted <= 1'b0;
					end
				default: begin
					st_reg <= mdfc_pkg::st_idle;
					halted <= 1'b0;
				end
			endcase
		end
	end

	property p_halt_entry;
		@(posedge aclk) disable iff (!aresetn)
		st_reg == mdfc_pkg::st_run && dma_on && !desc_avail |=> halted && halt_evt;
	endproperty
	a_halt_entry: assert property (p_halt_entry)
		else $error("dma did not halt without descriptor");

	property p_resume;
		@(posedge aclk) disable iff (!aresetn)
		halted && dma_on && demand |=> st_reg == mdfc_pkg::st_run;
	endproperty
	a_resume: assert property (p_resume)
		else $error("demand did not resume halted dma");

	property p_demand_ignored;
		@(posedge aclk) disable iff (!aresetn)
		st_reg == mdfc_pkg::st_run && dma_on && desc_avail && demand
			|=> st_reg == mdfc_pkg::st_run;
	endproperty
	a_demand_ignored: assert property (p_demand_ignored)
		else $error("demand outside halt changed state");
endmodule : mdfc_halt_fsm

// File: rtl/mdfc_rx_thresh.sv
// Receive FIFO high and low thresholds from the select and burst codes.
// Assumes the FIFO level is counted in bytes.
`timescale 1ns/100ps
module mdfc_rx_thresh #(
	parameter int LVL_W = 8
) (
	input  wire logic [1:0]       thd_sel,
	input  wire logic [1:0]       burst_len,
	output logic      [LVL_W-1:0] high_b,
	output logic      [LVL_W-1:0] low_b
);
	if (LVL_W < 8) begin : g_chk
		$error("LVL_W too narrow for 192 bytes");
	end

	function automatic int calc_high(input logic [1:0] sel, input logic [1:0] bl);
		int w;
		case (bl)
			2'h0: w = mdfc_pkg::BURST0_WORDS;
			2'h1: w = mdfc_pkg::BURST1_WORDS;
			2'h2: w = mdfc_pkg::BURST2_WORDS;
			default: w = mdfc_pkg::BURST3_WORDS;
		endcase
		case (sel)
			2'h0: calc_high = w * mdfc_pkg::BYTES_PER_WORD;
			2'h1: calc_high = mdfc_pkg::THD1_HIGH_B;
			2'h2: calc_high = mdfc_pkg::THD2_HIGH_B;
			default: calc_high = mdfc_pkg::THD3_HIGH_B;
		endcase
	endfunction : calc_high

	always_comb begin
		high_b = LVL_W'(calc_high(thd_sel, burst_len));
		low_b  = high_b >> 1;
	end
endmodule : mdfc_rx_thresh

// File: sim/mdfc_desc_model.sv
// Descriptor ring standing in for system memory on one DMA side.
// Assumes push and pop come from the bench just after a rising clock edge.
`timescale 1ns/100ps
module mdfc_desc_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic push,
	input  wire logic pop,
	output logic      avail
);
	logic [3:0] count_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			count_reg <= 4'h0;
		else if (push && !pop)
			count_reg <= count_reg + 4'h1;
		else if (pop && !push && count_reg != 4'h0)
			count_reg <= count_reg - 4'h1;
	end

	assign avail = (count_reg != 4'h0);
endmodule : mdfc_desc_model

// File: sim/mdfc_flow_ctrl_tb.sv
// Self-checking bench for the MAC DMA flow control block.
// Assumes the block's package and the descriptor ring model are compiled first.
`timescale 1ns/100ps
module mdfc_flow_ctrl_tb;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
	logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, burst_len, rsp, push = '0, pop = '0, avail;
	logic        rx_frame_active = '0, rx_frame_done = '0;
	logic [7:0]  rx_fifo_level = '0;
	logic [15:0] rx_frame_len = '0, m;
	logic        rx_dma_req, tx_dma_halted, rx_dma_halted, transmit_on, receive_on;
	int          fail_count = 0, comparisons = 0, h;

	always #50 aclk = ~aclk;

	mdfc_flow_ctrl #(.LVL_W(8)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tx_desc_avail(avail[0]), .rx_desc_avail(avail[1]), .rx_frame_active(rx_frame_active),
		.rx_fifo_level(rx_fifo_level), .rx_frame_done(rx_frame_done),
		.rx_frame_len(rx_frame_len), .rx_dma_req(rx_dma_req), .tx_dma_halted(tx_dma_halted),
		.rx_dma_halted(rx_dma_halted), .transmit_on(transmit_on), .receive_on(receive_on),
		.burst_len(burst_len), .irq(irq));
	mdfc_desc_model TXR (.aclk(aclk), .aresetn(aresetn), .push(push[0]), .pop(pop[0]),
		.avail(avail[0]));
	mdfc_desc_model RXR (.aclk(aclk), .aresetn(aresetn), .push(push[1]), .pop(pop[1]),
		.avail(avail[1]));

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic final_report;
		$display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	task automatic step(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask : step

	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		bit ah, wh, bh;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		do begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			rsp = bresp;
			@(posedge aclk);
			if (ah) awvalid <= 1'h0;
			if (wh) wvalid <= 1'h0;
			n++;
		end while (!bh && n < 40);
		bready <= 1'h0;
		if (!bh) chk("write answer", 32'h1, 32'h0);
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a);
		bit ah, rh;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do begin
			@(negedge aclk);
			ah = arvalid && arready;
			rh = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge aclk);
			if (ah) arvalid <= 1'h0;
			n++;
		end while (!rh && n < 40);
		rready <= 1'h0;
		if (!rh) chk("read answer", 32'h1, 32'h0);
	endtask : axi_rd

	function automatic logic [31:0] ctl(logic tx, logic rx, logic [1:0] s, logic [1:0] b, logic ov);
		return {23'h0, ov, 2'h0, b, s, rx, tx};
	endfunction : ctl

	function automatic int exp_high(int s, int b);
		if (s != 0)
			return 64 * s;
		return 4 * ((b == 0) ? 4 : (b == 1) ? 8 : 16);
	endfunction : exp_high

	task automatic ring(input int e, input logic up);
		@(posedge aclk);
		if (up) push[e] <= 1'h1;
		else pop[e] <= 1'h1;
		@(posedge aclk);
		push <= '0;
		pop <= '0;
	endtask : ring

	task automatic lvl(input int v, input logic e);
		@(posedge aclk);
		rx_fifo_level <= v[7:0];
		step(1);
		chk("rx_dma_req", {31'h0, e}, {31'h0, rx_dma_req});
	endtask : lvl

	task automatic frame(input logic [15:0] l);
		@(posedge aclk);
		rx_frame_done <= 1'h1;
		rx_frame_len <= l;
		@(posedge aclk);
		rx_frame_done <= 1'h0;
		step(1);
	endtask : frame

	task automatic halt_test(input int e);
		logic [31:0] dem;
		dem = e ? mdfc_pkg::ADDR_RX_DEMAND : mdfc_pkg::ADDR_TX_DEMAND;
		axi_wr(dem, $urandom());
		axi_wr(mdfc_pkg::ADDR_CTRL, ctl(e == 0, e == 1, 2'h1, 2'h0, 1'h0));
		chk("dma on", e ? 32'h2 : 32'h1, {30'h0, receive_on, transmit_on});
		step(4);
		chk("halted", 32'h1, {31'h0, e ? rx_dma_halted : tx_dma_halted});
		axi_rd(mdfc_pkg::ADDR_STATUS);
		chk("status halted", e ? 32'h2 : 32'h1, rd);
		ring(e, 1'h1);
		axi_wr(dem, $urandom());
		step(3);
		chk("resumed", 32'h0, {31'h0, e ? rx_dma_halted : tx_dma_halted});
		// A demand while running must not be kept for the next halt
		axi_wr(dem, $urandom());
		ring(e, 1'h0);
		step(3);
		chk("halted again", 32'h1, {31'h0, e ? rx_dma_halted : tx_dma_halted});
		axi_wr(mdfc_pkg::ADDR_CTRL, 32'h0);
	endtask : halt_test

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		void'($urandom(40158));
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		axi_rd(mdfc_pkg::ADDR_MAX_LEN);
		chk("max len reset", 32'h800, rd);
		axi_rd(mdfc_pkg::ADDR_TX_DEMAND);
		chk("tx demand rresp", {30'h0, mdfc_pkg::RESP_OKAY}, {30'h0, rsp});
		axi_rd(mdfc_pkg::ADDR_RX_DEMAND);
		chk("rx demand rresp", {30'h0, mdfc_pkg::RESP_OKAY}, {30'h0, rsp});
		axi_rd(32'hb00030f0);
		chk("unmapped rresp", {30'h0, mdfc_pkg::RESP_SLVERR}, {30'h0, rsp});
		axi_wr(32'hb00030f0, $urandom());
		chk("unmapped bresp", {30'h0, mdfc_pkg::RESP_SLVERR}, {30'h0, rsp});
		h = $urandom();
		axi_wr(mdfc_pkg::ADDR_MAX_LEN, h);
		axi_rd(mdfc_pkg::ADDR_MAX_LEN);
		chk("max len rw", h & 32'hffff, rd);
		ring(1, 1'h1);
		rx_frame_active <= 1'h1;
		for (int s = 0; s < 4; s++) begin
			for (int b = 0; b < 4; b++) begin
				if (s == 0 || b == 0) begin
					axi_wr(mdfc_pkg::ADDR_CTRL, ctl(1'h0, 1'h1, s[1:0], b[1:0], 1'h0));
					chk("burst_len", b, {30'h0, burst_len});
					h = exp_high(s, b);
					lvl(0, 1'h0);
					lvl(h - 1, 1'h0);
					lvl(h, 1'h1);
					lvl(h / 2, 1'h1);
					lvl(h / 2 - 1, 1'h0);
				end
			end
		end
		rx_frame_active <= 1'h0;
		ring(1, 1'h0);
		axi_wr(mdfc_pkg::ADDR_CTRL, 32'h0);
		halt_test(0);
		halt_test(1);
		axi_rd(mdfc_pkg::ADDR_IRQ_STAT);
		chk("halt flags", 32'h6, rd);
		m = 16'h05ef + 16'($urandom_range(2000));
		axi_wr(mdfc_pkg::ADDR_MAX_LEN, {16'h0, m});
		axi_wr(mdfc_pkg::ADDR_IRQ_MASK, 32'h1);
		axi_wr(mdfc_pkg::ADDR_IRQ_STAT, 32'h7);
		axi_wr(mdfc_pkg::ADDR_CTRL, ctl(1'h0, 1'h0, 2'h1, 2'h0, 1'h1));
		frame(m);
		chk("irq at max", 32'h0, {31'h0, irq});
		frame(m + 16'h1);
		chk("irq over max", 32'h1, {31'h0, irq});
		axi_rd(mdfc_pkg::ADDR_IRQ_STAT);
		chk("overlength flag", 32'h1, rd);
		axi_wr(mdfc_pkg::ADDR_IRQ_MASK, 32'h0);
		step(1);
		chk("irq masked", 32'h0, {31'h0, irq});
		axi_wr(mdfc_pkg::ADDR_IRQ_STAT, 32'h1);
		axi_wr(mdfc_pkg::ADDR_CTRL, 32'h0);
		frame(m + 16'h2);
		axi_rd(mdfc_pkg::ADDR_IRQ_STAT);
		chk("flag with enable off", 32'h0, rd);
		final_report;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		final_report;
	end
endmodule : mdfc_flow_ctrl_tb
